// >>> rtl/counter_channel_pkg.sv
// Shared constants for the counter channel host interface
package counter_channel_pkg;
  // ********************************************************************
  // Register byte offsets
  // ********************************************************************
  localparam logic [7:0] OFS_CTRL      = 8'h00; // Host control bits, write is an exchange
  localparam logic [7:0] OFS_CONFIG    = 8'h04; // Channel configuration
  localparam logic [7:0] OFS_REQ       = 8'h08; // Update request flags, write 1 to set
  localparam logic [7:0] OFS_STATUS    = 8'h0c; // Status and fault code
  localparam logic [7:0] OFS_READING   = 8'h10; // Counter reading snapshot
  localparam logic [7:0] OFS_MEAS      = 8'h14; // Measured value snapshot
  localparam logic [7:0] OFS_LATCHED   = 8'h18; // Latched counter value
  localparam logic [7:0] OFS_PEND_BASE = 8'h1c; // First of nine pending-value holders
  localparam logic [7:0] OFS_ACT_BASE  = 8'h40; // First of seven active values
  localparam logic [7:0] OFS_INTERVAL  = 8'h5c; // Measurement update interval in cycles minus one
  localparam int         NUM_PEND      = 9;
  localparam int         NUM_ACT       = 7;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int CTRL_LATCH_ARM  = 0;
  localparam int CTRL_PRESET_ARM = 1;
  localparam int CTRL_ALLOW_UP   = 2;
  localparam int CTRL_ALLOW_DOWN = 3;
  localparam int CTRL_EVENT_CLR  = 4;
  localparam int CTRL_FAULT_CLR  = 5;
  localparam int CTRL_W          = 6;

  localparam int CFG_LATCH_INPUT = 0; // Digital input assigned to capture
  localparam int CFG_LATCH_FALL  = 1; // Capture on falling instead of rising edge
  localparam int CFG_PRESET_INPUT= 2; // Digital input assigned to synchronization
  localparam int CFG_PRESET_INDEX= 3; // Synchronize at rising index pulse
  localparam int CFG_RELOAD_START= 4; // Limit reload uses start value
  localparam int CFG_CMP_MEAS    = 5; // compare_on_meas
  localparam int CFG_SINGLE_PULSE= 6; // Single pulse signalling, host sets direction
  localparam int CFG_W           = 7;

  // Request flag positions, also pending-holder indices 0..6
  localparam int REQ_REF0 = 0;
  localparam int REQ_REF1 = 1;
  localparam int REQ_HI   = 2;
  localparam int REQ_LO   = 3;
  localparam int REQ_LOAD = 4;
  localparam int REQ_START= 5;
  localparam int REQ_DIR  = 6;
  localparam int REQ_W    = 7;
  localparam int PEND_REF0_MEAS = 7;
  localparam int PEND_REF1_MEAS = 8;

  localparam int ST_LATCH_VALID = 0;
  localparam int ST_PRESET_DONE = 1;
  localparam int ST_EVT_LSB     = 2; // cmp0, cmp1, zero, high wrap, low wrap
  localparam int EVT_W          = 5;
  localparam int ST_FAULT       = 7;
  localparam int ST_CODE_LSB    = 16;

  // ********************************************************************
  // Reset values and fault codes
  // ********************************************************************
  localparam logic [31:0] RST_HI       = 32'h7fffffff;
  localparam logic [31:0] RST_LO       = 32'h80000000;
  localparam logic [31:0] RST_REF1     = 32'h0000000a;
  localparam logic [31:0] RST_INTERVAL = 32'h0001312d; // Measurement interval default
  localparam logic [31:0] DIR_UP_VAL   = 32'h00000001;
  localparam logic [31:0] DIR_DOWN_VAL = 32'hffffffff;
  localparam logic [7:0]  FLT_NONE     = 8'h00;
  localparam logic [7:0]  FLT_HI_LIMIT = 8'h01;
  localparam logic [7:0]  FLT_LO_LIMIT = 8'h02;
  localparam logic [7:0]  FLT_LOAD     = 8'h03;
  localparam logic [7:0]  FLT_START    = 8'h04;
  localparam logic [7:0]  FLT_DIR      = 8'h05;
endpackage : counter_channel_pkg

// >>> rtl/ctrl_edges.sv
// Edge detection of host control bits between two exchanges
`timescale 1ns/1ps
module ctrl_edges #(
  parameter int W = 6
) (
  input  wire logic         hclk,    // Clock
  input  wire logic         hresetn, // Async reset, active low
  input  wire logic         strobe,  // Exchange strobe
  input  wire logic [W-1:0] d,       // Newly exchanged bits
  output logic      [W-1:0] q,       // Value held from last exchange
  output logic      [W-1:0] rise,    // Rising edge at this exchange
  output logic      [W-1:0] fall     // Falling edge at this exchange
);
  // ********************************************************************
  // Per-bit compare against the held value
  // ********************************************************************
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic held_reg;
    logic held_next;
    // Edges exist only at the exchange itself
    always_comb
    begin
      held_next = strobe ? d[i] : held_reg;
      rise[i]   = strobe & d[i] & ~held_reg;
      fall[i]   = strobe & ~d[i] & held_reg;
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        held_reg <= 1'b0;
      else
        held_reg <= held_next;
    end
    assign q[i] = held_reg;
  end
endmodule : ctrl_edges

// >>> rtl/meas_unit.sv
// Measurement of pulses per update interval, free of host exchanges
`timescale 1ns/1ps
module meas_unit (
  input  wire logic        hclk,        // Clock
  input  wire logic        hresetn,     // Async reset, active low
  input  wire logic        count_pulse, // One-cycle count strobe
  input  wire logic [31:0] interval,    // Interval length in cycles minus one, 0 = every cycle
  output logic      [31:0] result,      // Last finished measurement
  output logic             updated      // One-cycle pulse at each new result
);
  import counter_channel_pkg::*;
  logic [31:0] tick_reg, tick_next;
  logic [31:0] acc_reg, acc_next;
  logic [31:0] res_reg, res_next;
  logic        upd_reg, upd_next;
  logic [31:0] acc_in;

  // ********************************************************************
  // Interval timer and pulse accumulator
  // ********************************************************************
  // The host never sees a half-built sum: only closed intervals publish
  always_comb
  begin
    acc_in    = acc_reg + {31'h0, count_pulse};
    tick_next = tick_reg + 32'h1;
    acc_next  = acc_in;
    res_next  = res_reg;
    upd_next  = 1'b0;
    if (tick_reg >= interval)
    begin
      tick_next = 32'h0;
      acc_next  = 32'h0;
      res_next  = acc_in;
      upd_next  = 1'b1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_reg <= 32'h0;
      acc_reg  <= 32'h0;
      res_reg  <= 32'h0;
      upd_reg  <= 1'b0;
    end
    else
    begin
      tick_reg <= tick_next;
      acc_reg  <= acc_next;
      res_reg  <= res_next;
      upd_reg  <= upd_next;
    end
  end
  assign result  = res_reg;
  assign updated = upd_reg;
endmodule : meas_unit

// >>> rtl/counter_channel_host_interface.sv
// Counter channel with AHB-Lite host exchange, latch, preset and parameter handshake
// Behaviour
// - Every exchange snapshots the current counter reading for the host.
// - Measured value refreshes on its own interval; each exchange shows the latest.
// - Latch counter only with input assigned, arm bit set and configured edge.
// - latch_valid set on capture, cleared on falling edge of latch_arm.
// - Preset needs source configured, arm, direction allowed and input or index edge.
// - preset_done set once a preset has happened.
// - preset_done cleared on falling edge of arm, allow-up or allow-down bit.
// - Channel clears request flag when done; failure raises the fault output.
// - Seven request flags with pending holders exist.
// - New upper limit below reading reloads lower limit or start value.
// - New lower limit above reading reloads upper limit or start value.
// - Compare source clear: counter with count-based references.
// - Compare source set: measured value with measurement references.
// - Rising event_clear_req clears the five event status bits.
// - Fault stays until fault_clear_req; no new fault before acknowledge.
// - Direction change only in single pulse mode; +1 up, -1 down.
`timescale 1ns/1ps
module counter_channel_host_interface (
  input  wire logic        hclk,        // Clock, 125 MHz
  input  wire logic        hresetn,     // Async reset, active low
  input  wire logic        hsel,        // AHB slave select
  input  wire logic [31:0] haddr,       // AHB address
  input  wire logic [1:0]  htrans,      // AHB transfer type
  input  wire logic        hwrite,      // AHB write
  input  wire logic [2:0]  hsize,       // AHB size, word only
  input  wire logic [31:0] hwdata,      // AHB write data
  input  wire logic        hready,      // AHB bus ready
  output logic      [31:0] hrdata,      // AHB read data
  output logic             hreadyout,   // AHB slave ready
  output logic             hresp,       // AHB response, always OKAY
  input  wire logic        count_pulse, // One-cycle count strobe
  input  wire logic        count_dir,   // Direction pin, 1 = up
  input  wire logic        latch_di,    // Digital input for capture
  input  wire logic        preset_di,   // Digital input for synchronization
  input  wire logic        index_in,    // Encoder index signal
  output logic             fault_out    // Fault output level
);
  import counter_channel_pkg::*;

  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic               ph_wr_reg, ph_wr_next, ph_rd_reg, ph_rd_next;
  logic [7:0]         ph_adr_reg, ph_adr_next;
  logic               rdy_reg, rdy_next;
  logic [31:0]        rdata_reg, rdata_next, rd_mux;
  logic [CTRL_W-1:0]  ctrl_q, ctrl_rise, ctrl_fall;
  logic [CFG_W-1:0]   cfg_reg, cfg_next;
  logic [REQ_W-1:0]   req_reg, req_next;
  logic [31:0]        pend_reg [NUM_PEND];
  logic [31:0]        pend_next [NUM_PEND];
  logic [31:0]        act_reg [NUM_ACT];
  logic [31:0]        act_next [NUM_ACT];
  logic [31:0]        interval_reg, interval_next;
  logic               fault_reg, fault_next;
  logic [7:0]         code_reg, code_next;
  logic               dir_up_reg, dir_up_next;
  logic signed [31:0] cnt_reg, cnt_next;
  logic [31:0]        snap_cnt_reg, snap_cnt_next, snap_meas_reg, snap_meas_next;
  logic [31:0]        latched_reg, latched_next;
  logic               latch_valid_reg, latch_valid_next;
  logic               preset_done_reg, preset_done_next;
  logic [EVT_W-1:0]   evt_reg, evt_next, evt_set;
  logic               ldi_reg, pdi_reg, idx_reg;
  logic [31:0]        meas_val;
  logic               exchange, wr_cmt, err, err_pending, cnt_up;
  logic [7:0]         err_code;
  logic signed [31:0] hi_s, lo_s, pv, src, r0, r1;
  logic               reload_hit, latch_edge, preset_edge, preset_fire;
  logic signed [31:0] reload_val;

  // ********************************************************************
  // Sub-blocks
  // ********************************************************************
  assign wr_cmt   = ph_wr_reg;
  assign exchange = wr_cmt && (ph_adr_reg == OFS_CTRL);

  ctrl_edges #(.W(CTRL_W)) u_edges (
    .hclk    (hclk),
    .hresetn (hresetn),
    .strobe  (exchange),
    .d       (hwdata[CTRL_W-1:0]),
    .q       (ctrl_q),
    .rise    (ctrl_rise),
    .fall    (ctrl_fall)
  );

  meas_unit u_meas (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .count_pulse (count_pulse),
    .interval    (interval_reg),
    .result      (meas_val),
    .updated     ()
  );

  // ********************************************************************
  // AHB-Lite slave
  // ********************************************************************
  // Reads take one wait state so a write just ahead is already visible
  always_comb
  begin
    rd_mux = 32'h0;
    case (ph_adr_reg)
      OFS_CTRL:     rd_mux = {26'h0, ctrl_q};
      OFS_CONFIG:   rd_mux = {25'h0, cfg_reg};
      OFS_REQ:      rd_mux = {25'h0, req_reg};
      OFS_STATUS:   rd_mux = {8'h0, code_reg, 8'h0, fault_reg, evt_reg,
                              preset_done_reg, latch_valid_reg};
      OFS_READING:  rd_mux = snap_cnt_reg;
      OFS_MEAS:     rd_mux = snap_meas_reg;
      OFS_LATCHED:  rd_mux = latched_reg;
      OFS_INTERVAL: rd_mux = interval_reg;
      default:
      begin
        for (int i = 0; i < NUM_PEND; i++)
          if (ph_adr_reg == OFS_PEND_BASE + 8'(4 * i))
            rd_mux = pend_reg[i];
        for (int i = 0; i < NUM_ACT; i++)
          if (ph_adr_reg == OFS_ACT_BASE + 8'(4 * i))
            rd_mux = act_reg[i];
      end
    endcase
    ph_wr_next  = 1'b0;
    ph_rd_next  = 1'b0;
    ph_adr_next = ph_adr_reg;
    rdy_next    = 1'b1;
    rdata_next  = rdata_reg;
    if (ph_rd_reg)
      rdata_next = rd_mux;
    if (hsel && htrans[1] && hready)
    begin
      ph_adr_next = (haddr[31:8] == 24'h0) ? {haddr[7:2], 2'b00} : 8'hff;
      ph_wr_next  = hwrite;
      ph_rd_next  = !hwrite;
      rdy_next    = hwrite;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr_reg  <= 1'b0;
      ph_rd_reg  <= 1'b0;
      ph_adr_reg <= 8'h0;
      rdy_reg    <= 1'b1;
      rdata_reg  <= 32'h0;
    end
    else
    begin
      ph_wr_reg  <= ph_wr_next;
      ph_rd_reg  <= ph_rd_next;
      ph_adr_reg <= ph_adr_next;
      rdy_reg    <= rdy_next;
      rdata_reg  <= rdata_next;
    end
  end
  assign hrdata    = rdata_reg;
  assign hreadyout = rdy_reg;
  assign hresp     = 1'b0;

  // ********************************************************************
  // Parameter handshake, configuration and fault
  // ********************************************************************
  // One request is served per cycle, lowest flag first; failure keeps the old value
  always_comb
  begin
    cfg_next      = cfg_reg;
    req_next      = req_reg;
    interval_next = interval_reg;
    dir_up_next   = dir_up_reg;
    pend_next     = pend_reg;
    act_next      = act_reg;
    err           = 1'b0;
    err_code      = FLT_NONE;
    reload_hit    = 1'b0;
    reload_val    = cnt_reg;
    hi_s          = signed'(act_reg[REQ_HI]);
    lo_s          = signed'(act_reg[REQ_LO]);
    pv            = 32'sh0;
    for (int k = REQ_W - 1; k >= 0; k--)
    begin
      if (req_reg[k] && !err && !reload_hit)
        pv = signed'(pend_reg[k]);
    end
    casez (req_reg)
      7'b??????1:
      begin
        act_next[REQ_REF0] = pend_reg[REQ_REF0];
        act_next[PEND_REF0_MEAS - 2] = pend_reg[PEND_REF0_MEAS];
        req_next[REQ_REF0] = 1'b0;
      end
      7'b?????10:
      begin
        act_next[REQ_REF1] = pend_reg[REQ_REF1];
        act_next[PEND_REF1_MEAS - 2] = pend_reg[PEND_REF1_MEAS];
        req_next[REQ_REF1] = 1'b0;
      end
      7'b????100:
      begin
        req_next[REQ_HI] = 1'b0;
        if (pv < lo_s)
          {err, err_code} = {1'b1, FLT_HI_LIMIT};
        else
        begin
          act_next[REQ_HI] = pend_reg[REQ_HI];
          reload_hit = (pv < cnt_reg);
          reload_val = cfg_reg[CFG_RELOAD_START] ? signed'(act_reg[REQ_START]) : lo_s;
        end
      end
      7'b???1000:
      begin
        req_next[REQ_LO] = 1'b0;
        if (pv > hi_s)
          {err, err_code} = {1'b1, FLT_LO_LIMIT};
        else
        begin
          act_next[REQ_LO] = pend_reg[REQ_LO];
          reload_hit = (pv > cnt_reg);
          reload_val = cfg_reg[CFG_RELOAD_START] ? signed'(act_reg[REQ_START]) : hi_s;
        end
      end
      7'b??10000:
      begin
        req_next[REQ_LOAD] = 1'b0;
        if (pv > hi_s || pv < lo_s)
          {err, err_code} = {1'b1, FLT_LOAD};
        else
          {reload_hit, reload_val} = {1'b1, pv};
      end
      7'b?100000:
      begin
        req_next[REQ_START] = 1'b0;
        if (pv > hi_s || pv < lo_s)
          {err, err_code} = {1'b1, FLT_START};
        else
          act_next[REQ_START] = pend_reg[REQ_START];
      end
      7'b1000000:
      begin
        req_next[REQ_DIR] = 1'b0;
        if (!cfg_reg[CFG_SINGLE_PULSE] ||
            (pend_reg[REQ_DIR] != DIR_UP_VAL && pend_reg[REQ_DIR] != DIR_DOWN_VAL))
          {err, err_code} = {1'b1, FLT_DIR};
        else
          dir_up_next = (pend_reg[REQ_DIR] == DIR_UP_VAL);
      end
      default: ;
    endcase
    // Host writes; a set written in the cycle the channel clears still wins
    if (wr_cmt)
    begin
      if (ph_adr_reg == OFS_CONFIG)
        cfg_next = hwdata[CFG_W-1:0];
      if (ph_adr_reg == OFS_REQ)
        req_next = req_next | hwdata[REQ_W-1:0];
      if (ph_adr_reg == OFS_INTERVAL)
        interval_next = hwdata;
      for (int i = 0; i < NUM_PEND; i++)
        if (ph_adr_reg == OFS_PEND_BASE + 8'(4 * i))
          pend_next[i] = hwdata;
    end
    // A raised fault holds its code; later failures stay unsignalled
    err_pending = err && !fault_reg;
    fault_next  = fault_reg;
    code_next   = code_reg;
    if (ctrl_rise[CTRL_FAULT_CLR] && !err)
      {fault_next, code_next} = {1'b0, FLT_NONE};
    if (err && (!fault_reg || ctrl_rise[CTRL_FAULT_CLR]))
      {fault_next, code_next} = {1'b1, err_code};
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_reg      <= '0;
      req_reg      <= '0;
      interval_reg <= RST_INTERVAL;
      dir_up_reg   <= 1'b1;
      fault_reg    <= 1'b0;
      code_reg     <= FLT_NONE;
      for (int i = 0; i < NUM_PEND; i++)
        pend_reg[i] <= 32'h0;
      for (int i = 0; i < NUM_ACT; i++)
        act_reg[i] <= 32'h0;
      act_reg[REQ_REF1]           <= RST_REF1;
      act_reg[PEND_REF1_MEAS - 2] <= RST_REF1;
      act_reg[REQ_HI]             <= RST_HI;
      act_reg[REQ_LO]             <= RST_LO;
    end
    else
    begin
      cfg_reg      <= cfg_next;
      req_reg      <= req_next;
      interval_reg <= interval_next;
      dir_up_reg   <= dir_up_next;
      fault_reg    <= fault_next;
      code_reg     <= code_next;
      pend_reg     <= pend_next;
      act_reg      <= act_next;
    end
  end
  assign fault_out = fault_reg;

  // ********************************************************************
  // Counter, latch, preset, compare and events
  // ********************************************************************
  // Priority: parameter load, then preset, then the count step
  always_comb
  begin
    cnt_up      = cfg_reg[CFG_SINGLE_PULSE] ? dir_up_reg : count_dir;
    latch_edge  = cfg_reg[CFG_LATCH_FALL] ? (ldi_reg && !latch_di) : (!ldi_reg && latch_di);
    preset_edge = (cfg_reg[CFG_PRESET_INPUT] && !pdi_reg && preset_di) ||
                  (cfg_reg[CFG_PRESET_INDEX] && !idx_reg && index_in);
    preset_fire = preset_edge && ctrl_q[CTRL_PRESET_ARM] &&
                  (cnt_up ? ctrl_q[CTRL_ALLOW_UP] : ctrl_q[CTRL_ALLOW_DOWN]);
    evt_set  = '0;
    cnt_next = cnt_reg;
    if (reload_hit)
      cnt_next = reload_val;
    else if (preset_fire)
      cnt_next = signed'(act_reg[REQ_START]);
    else if (count_pulse && cnt_up)
    begin
      cnt_next   = (cnt_reg == hi_s) ? lo_s : cnt_reg + 32'sh1;
      evt_set[3] = (cnt_reg == hi_s);
    end
    else if (count_pulse)
    begin
      cnt_next   = (cnt_reg == lo_s) ? hi_s : cnt_reg - 32'sh1;
      evt_set[4] = (cnt_reg == lo_s);
    end
    evt_set[2] = (cnt_next == 32'sh0) && (cnt_reg != 32'sh0);
    // Only the references of the selected source are looked at
    src = cfg_reg[CFG_CMP_MEAS] ? signed'(meas_val) : cnt_reg;
    r0  = cfg_reg[CFG_CMP_MEAS] ? signed'(act_reg[PEND_REF0_MEAS - 2])
                                : signed'(act_reg[REQ_REF0]);
    r1  = cfg_reg[CFG_CMP_MEAS] ? signed'(act_reg[PEND_REF1_MEAS - 2])
                                : signed'(act_reg[REQ_REF1]);
    evt_set[0] = (src == r0);
    evt_set[1] = (src == r1);
    // Set wins over the acknowledge clear
    evt_next = evt_reg;
    if (ctrl_rise[CTRL_EVENT_CLR])
      evt_next = '0;
    evt_next = evt_next | evt_set;
    latched_next     = latched_reg;
    latch_valid_next = latch_valid_reg;
    if (ctrl_fall[CTRL_LATCH_ARM])
      latch_valid_next = 1'b0;
    if (cfg_reg[CFG_LATCH_INPUT] && ctrl_q[CTRL_LATCH_ARM] && latch_edge)
      {latch_valid_next, latched_next} = {1'b1, cnt_reg};
    preset_done_next = preset_done_reg;
    if (ctrl_fall[CTRL_PRESET_ARM] || ctrl_fall[CTRL_ALLOW_UP] || ctrl_fall[CTRL_ALLOW_DOWN])
      preset_done_next = 1'b0;
    if (preset_fire)
      preset_done_next = 1'b1;
    snap_cnt_next  = exchange ? cnt_reg : snap_cnt_reg;
    snap_meas_next = exchange ? meas_val : snap_meas_reg;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg         <= 32'sh0;
      evt_reg         <= '0;
      latched_reg     <= 32'h0;
      latch_valid_reg <= 1'b0;
      preset_done_reg <= 1'b0;
      snap_cnt_reg    <= 32'h0;
      snap_meas_reg   <= 32'h0;
      ldi_reg         <= 1'b0;
      pdi_reg         <= 1'b0;
      idx_reg         <= 1'b0;
    end
    else
    begin
      cnt_reg         <= cnt_next;
      evt_reg         <= evt_next;
      latched_reg     <= latched_next;
      latch_valid_reg <= latch_valid_next;
      preset_done_reg <= preset_done_next;
      snap_cnt_reg    <= snap_cnt_next;
      snap_meas_reg   <= snap_meas_next;
      ldi_reg         <= latch_di;
      pdi_reg         <= preset_di;
      idx_reg         <= index_in;
    end
  end
endmodule : counter_channel_host_interface

// >>> tb/ccp_props.sv
// Bus and fault checks for the counter channel
`timescale 1ns/1ps
module ccp_props (
  input wire logic        hclk,      // Clock
  input wire logic        hresetn,   // Reset, active low
  input wire logic        hsel,      // Select
  input wire logic [31:0] haddr,     // Address
  input wire logic [1:0]  htrans,    // Transfer type
  input wire logic        hwrite,    // Write
  input wire logic        hready,    // Bus ready
  input wire logic [31:0] hrdata,    // Read data
  input wire logic        hreadyout, // Slave ready
  input wire logic        hresp,     // Response
  input wire logic        fault_out  // Fault level
);
  import counter_channel_pkg::*;
  logic        rd1; // Read wait cycle
  logic        wdp; // Write data phase
  logic [31:0] dpa; // Data phase address
  wire         ap = hsel && htrans[1] && hready;
  // ****
  // Data phase tracking; a write commits at the end of wdp
  // ****
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rd1 <= 1'b0;
      wdp <= 1'b0;
      dpa <= 32'h0;
    end
    else
    begin
      rd1 <= ap && !hwrite;
      wdp <= ap && hwrite;
      if (ap) dpa <= haddr;
    end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Reads cost one wait cycle, writes none
  resp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
  read_wait_a: assert property (ap && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  write_nowait_a: assert property (ap && hwrite |=> hreadyout) else $error("write stalled");
  ready_low_a: assert property (hreadyout == !rd1) else $error("hreadyout wrong");
  rdata_hold_a: assert property (!rd1 |=> $stable(hrdata)) else $error("hrdata moved");
  unmapped_zero_a: assert property (rd1 && dpa >= 32'h100 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  // Only a control exchange may drop the fault level
  fault_clear_a: assert property ($fell(fault_out) |-> $past(wdp && dpa == OFS_CTRL))
    else $error("fault dropped alone");
  fault_keep_a: assert property (fault_out && !(wdp && dpa == OFS_CTRL) |=> fault_out)
    else $error("fault not held");
  cover property (ap && !hwrite);
  cover property (ap && hwrite);
  cover property ($fell(fault_out));
endmodule : ccp_props
bind counter_channel_host_interface ccp_props u_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fault_out(fault_out));

// >>> tb/tb_top.sv
// Self-checking bench for the counter channel host interface
`timescale 1ns/1ps
module tb_top;
  import counter_channel_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, count_pulse = 0, latch_di = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0]  htrans = 0;
  logic        hreadyout, hresp, fault_out;
  wire         hready = hreadyout; // Single slave drives bus ready
  int          miscompares = 0, checked = 0, cyc = 0;
  // ****
  // Rows of address and reset value; the last is unmapped
  // ****
  logic [31:0] rows [8][2] = '{'{32'h44, RST_REF1}, '{32'h48, RST_HI}, '{32'h4c, RST_LO},
    '{32'h50, 32'h0}, '{32'h58, RST_REF1}, '{32'h5c, RST_INTERVAL}, '{32'h08, 32'h0},
    '{32'h200, 32'h0}};
  counter_channel_host_interface DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .count_pulse(count_pulse), .count_dir(1'b1), .latch_di(latch_di), .preset_di(1'b0),
    .index_in(1'b0), .fault_out(fault_out));
  initial forever #4 hclk = ~hclk;
  // Cut a hang short well above the roughly 140 cycles needed
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      stop_test;
    end
  end
  task stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch at %0t: %h vs %h", $time, s, e);
    end
  endtask : chk
  // One whole-word transfer; read data is taken at the edge that ends the data phase
  task bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task poll;
    repeat (20)
    begin
      bus(0, OFS_REQ, 0, r);
      if (r == 32'h0) break;
    end
  endtask : poll
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i])
    begin
      bus(0, rows[i][0], 0, r);
      chk(r, rows[i][1]);
    end
    repeat (5)
    begin
      @(posedge hclk) count_pulse <= 1'b1;
      @(posedge hclk) count_pulse <= 1'b0;
    end
    bus(1, OFS_CTRL, 0, r);
    bus(0, OFS_READING, 0, r);
    chk(r, 32'h5);
    // Upper limit below the reading reloads the lower limit
    bus(1, OFS_PEND_BASE + 8'h08, 32'h2, r);
    bus(1, OFS_REQ, 32'h4, r);
    poll;
    chk(r, 32'h0);
    bus(1, OFS_CTRL, 0, r);
    bus(0, OFS_READING, 0, r);
    chk(r, RST_LO);
    // Lower limit above upper limit must fail and stay unapplied
    bus(1, OFS_PEND_BASE + 8'h0c, 32'h3, r);
    bus(1, OFS_REQ, 32'h8, r);
    poll;
    chk(fault_out, 1'b1);
    bus(0, OFS_STATUS, 0, r);
    chk(r & 32'h00ff0080, {FLT_LO_LIMIT, 16'h0080});
    bus(0, OFS_ACT_BASE + 8'h0c, 0, r);
    chk(r, RST_LO);
    bus(1, OFS_CTRL, 32'h20, r);
    @(posedge hclk);
    chk(fault_out, 1'b0);
    // Arm latch with events cleared, then drop the arm
    bus(1, OFS_CONFIG, 32'h1, r);
    bus(1, OFS_CTRL, 32'h31, r);
    latch_di <= 1'b1;
    bus(0, OFS_STATUS, 0, r);
    chk(r & 32'h7f, 32'h1);
    bus(0, OFS_LATCHED, 0, r);
    chk(r, RST_LO);
    bus(1, OFS_CTRL, 32'h20, r);
    bus(0, OFS_STATUS, 0, r);
    chk(r & 32'h1, 32'h0);
    // Host sets down counting in single pulse mode; one pulse wraps low to high
    poll;
    bus(1, OFS_CONFIG, 32'h40, r);
    bus(1, OFS_PEND_BASE + 8'h18, DIR_DOWN_VAL, r);
    bus(1, OFS_REQ, 32'h40, r);
    poll;
    chk(fault_out, 1'b0);
    @(posedge hclk) count_pulse <= 1'b1;
    @(posedge hclk) count_pulse <= 1'b0;
    bus(1, OFS_CTRL, 32'h20, r);
    bus(0, OFS_READING, 0, r);
    chk(r, 32'h2);
    stop_test;
  end
endmodule : tb_top
